// [common/agc_pkg.sv]
/*
 * Constants for the module-wide control registers of a six-channel
 * acquisition card: register offsets, field positions, reset values and
 * trigger source codes.
 * Assumes a 16-bit host register port clocked with the card's logic.
 */
`default_nettype none

package agc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_CHAN = 6;
    localparam int LEVEL_W = 12;

    localparam logic [7:0] OFS_FAIL_IRQ  = 8'h00;
    localparam logic [7:0] OFS_TRIG_ARM  = 8'h02;
    localparam logic [7:0] OFS_RESERVED  = 8'h04;
    localparam logic [7:0] OFS_THRESHOLD = 8'h06;
    localparam logic [7:0] OFS_CHAN_BASE = 8'h08;
    localparam logic [7:0] OFS_CHAN_STEP = 8'h28;
    localparam logic [7:0] OFS_CHAN_END  = 8'hF8;

    localparam int POS_FAIL_MASK = 14;
    localparam int POS_IRQ_LO    = 0;
    localparam int POS_SRC_LO    = 13;
    localparam int POS_EDGE      = 12;
    localparam int POS_SOFT_LO   = 6;
    localparam int POS_ARM_LO    = 0;

    localparam logic        RST_FAIL_MASK = 1'h0;
    localparam logic [2:0]  RST_IRQ_LEVEL = 3'h0;
    localparam logic [2:0]  RST_SRC       = 3'h0;
    localparam logic        RST_EDGE      = 1'h0;
    localparam logic [5:0]  RST_SOFT      = 6'h00;
    localparam logic [5:0]  RST_ARM       = 6'h00;
    localparam logic [11:0] RST_THRESHOLD = 12'h000;

    localparam logic [2:0] SRC_EXTERNAL = 3'h6;
    localparam logic [2:0] IRQ_NONE     = 3'h0;

    typedef enum logic {
        AGC_EDGE_RISING,
        AGC_EDGE_FALLING
    } agc_edge_type;

endpackage

`default_nettype wire

// [hdl/agc_edge_detect.sv]
/*
 * Per-bit rise and fall detector for a vector of register bits.
 * Assumes the vector is driven by logic on the same clock.
 */
`default_nettype none

module agc_edge_detect #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    // Watched vector and its edges
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] next_last;

    // All bits are compared at once, so one write acts on every channel.
    always_comb begin
        next_last = level;
        rise      = level & ~last;
        fall      = last & ~level;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            last <= '0;
        end else begin
            last <= next_last;
        end
    end

endmodule

`default_nettype wire

// [hdl/agc_outside_trigger.sv]
/*
 * Threshold crossing detector for the outside trigger input.
 * Assumes samples arrive from the card's converter logic on the same
 * clock, each marked by a one-cycle valid strobe.
 */
`default_nettype none

module agc_outside_trigger
    import agc_pkg::*;
#(
    parameter int WIDTH = LEVEL_W
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    // Settings
    input  wire logic [WIDTH-1:0] threshold,
    input  wire logic             falling,
    // Samples and the detected crossing
    input  wire logic             sample_valid,
    input  wire logic [WIDTH-1:0] sample,
    output logic                  crossed
);

    logic above;
    logic next_above;
    logic primed;
    logic next_primed;
    logic now_above;

    always_comb begin
        now_above   = sample >= threshold;
        next_above  = above;
        next_primed = primed;
        crossed     = 1'b0;
        if (sample_valid) begin
            next_above  = now_above;
            next_primed = 1'b1;
            // A first sample after reset has no history and never fires.
            if (primed) begin
                if (falling == AGC_EDGE_FALLING) begin
                    crossed = above && !now_above;
                end else begin
                    crossed = !above && now_above;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            above  <= 1'b0;
            primed <= 1'b0;
        end else begin
            above  <= next_above;
            primed <= next_primed;
        end
    end

endmodule

`default_nettype wire

// [hdl/agc_global_regs.sv]
/*
 * Module-wide control registers of the six-channel acquisition card:
 * fail-line mask, interrupt request level, fast trigger source, outside
 * trigger edge and threshold, soft trigger and arm bits.
 * Assumes a 16-bit host port on the same clock as the card logic, with a
 * one-cycle strobe per access, and per-channel blocks that answer their
 * own offsets from the decode given here.
 */
`default_nettype none

module agc_global_regs
    import agc_pkg::*;
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rstn,
    // Host register port
    input  wire logic                host_strobe,
    input  wire logic                host_write,
    input  wire logic [ADDR_W-1:0]   host_addr,
    input  wire logic [DATA_W-1:0]   host_wdata,
    output logic      [DATA_W-1:0]   host_rdata,
    output logic                     host_ack,
    // Per-channel register decode
    output logic                     chan_reg_hit,
    output logic      [2:0]          chan_reg_index,
    output logic      [5:0]          chan_reg_offset,
    // System fail line, open drain
    input  wire logic                card_fail,
    output logic                     sysfail_out,
    output logic                     sysfail_oe_n,
    // Interrupt request
    input  wire logic [NUM_CHAN-1:0] chan_irq,
    output logic      [2:0]          irq_request_level,
    // Trigger sources
    input  wire logic [3:0]          slow_chan_trigger,
    input  wire logic                outside_sample_valid,
    input  wire logic [LEVEL_W-1:0]  outside_sample,
    output logic                     fast_channel_trigger,
    // Channel control
    output logic      [NUM_CHAN-1:0] channel_arm_bits,
    output logic      [NUM_CHAN-1:0] channel_force_trigger,
    output logic      [NUM_CHAN-1:0] channel_abort
);

    // Register state.
    logic                fail_line_mask;
    logic [2:0]          irq_priority_level;
    logic [2:0]          fast_channel_trigger_select;
    logic                outside_trigger_edge;
    logic [NUM_CHAN-1:0] soft_trigger_bits;
    logic [NUM_CHAN-1:0] arm_bits;
    logic [LEVEL_W-1:0]  outside_trigger_threshold;

    logic                next_fail_line_mask;
    logic [2:0]          next_irq_priority_level;
    logic [2:0]          next_fast_channel_trigger_select;
    logic                next_outside_trigger_edge;
    logic [NUM_CHAN-1:0] next_soft_trigger_bits;
    logic [NUM_CHAN-1:0] next_arm_bits;
    logic [LEVEL_W-1:0]  next_outside_trigger_threshold;

    // Host answer and decode outputs.
    logic [DATA_W-1:0]   next_host_rdata;
    logic                next_host_ack;
    logic                next_chan_reg_hit;
    logic [2:0]          next_chan_reg_index;
    logic [5:0]          next_chan_reg_offset;

    // Pin and channel outputs.
    logic                next_sysfail_oe_n;
    logic [2:0]          next_irq_request_level;
    logic                next_fast_channel_trigger;
    logic [NUM_CHAN-1:0] next_channel_force_trigger;
    logic [NUM_CHAN-1:0] next_channel_abort;

    // Edge detector results.
    logic [NUM_CHAN-1:0] soft_rise;
    logic [NUM_CHAN-1:0] arm_fall;
    logic                outside_crossed;

    logic                own_hit;
    logic                word_aligned;

    // Maps a byte offset in the per-channel area to its channel and the
    // offset within that channel's block.
    function automatic logic [8:0] chan_decode(input logic [7:0] addr);
        logic [7:0] rest;
        logic [2:0] idx;
        rest = addr - OFS_CHAN_BASE;
        idx  = 3'h0;
        for (int i = 0; i < NUM_CHAN - 1; i++) begin
            if (rest >= OFS_CHAN_STEP) begin
                rest = rest - OFS_CHAN_STEP;
                idx  = idx + 3'h1;
            end
        end
        chan_decode = {idx, rest[5:0]};
    endfunction

    // Host register access.
    always_comb begin
        next_fail_line_mask              = fail_line_mask;
        next_irq_priority_level          = irq_priority_level;
        next_fast_channel_trigger_select = fast_channel_trigger_select;
        next_outside_trigger_edge        = outside_trigger_edge;
        next_soft_trigger_bits           = soft_trigger_bits;
        next_arm_bits                    = arm_bits;
        next_outside_trigger_threshold   = outside_trigger_threshold;
        next_host_rdata                  = host_rdata;
        next_host_ack                    = 1'b0;
        next_chan_reg_hit                = 1'b0;
        next_chan_reg_index              = chan_reg_index;
        next_chan_reg_offset             = chan_reg_offset;
        // Odd byte addresses would be half of a wider transfer; these
        // registers only take whole 16-bit words.
        word_aligned = !host_addr[0];
        own_hit      = host_strobe && word_aligned
                       && (host_addr < OFS_CHAN_BASE);
        if (own_hit) begin
            next_host_ack   = 1'b1;
            next_host_rdata = '0;
            case (host_addr)
                OFS_FAIL_IRQ: begin
                    if (host_write) begin
                        next_fail_line_mask = host_wdata[POS_FAIL_MASK];
                        next_irq_priority_level =
                            host_wdata[POS_IRQ_LO +: 3];
                    end else begin
                        next_host_rdata[POS_FAIL_MASK] = fail_line_mask;
                        next_host_rdata[POS_IRQ_LO +: 3] =
                            irq_priority_level;
                    end
                end
                OFS_TRIG_ARM: begin
                    if (host_write) begin
                        next_fast_channel_trigger_select =
                            host_wdata[POS_SRC_LO +: 3];
                        next_outside_trigger_edge =
                            host_wdata[POS_EDGE];
                        next_soft_trigger_bits =
                            host_wdata[POS_SOFT_LO +: NUM_CHAN];
                        next_arm_bits =
                            host_wdata[POS_ARM_LO +: NUM_CHAN];
                    end else begin
                        next_host_rdata[POS_SRC_LO +: 3] =
                            fast_channel_trigger_select;
                        next_host_rdata[POS_EDGE] = outside_trigger_edge;
                        next_host_rdata[POS_SOFT_LO +: NUM_CHAN] =
                            soft_trigger_bits;
                        next_host_rdata[POS_ARM_LO +: NUM_CHAN] = arm_bits;
                    end
                end
                OFS_THRESHOLD: begin
                    if (host_write) begin
                        next_outside_trigger_threshold =
                            host_wdata[LEVEL_W-1:0];
                    end else begin
                        next_host_rdata[LEVEL_W-1:0] =
                            outside_trigger_threshold;
                    end
                end
                default: begin
                    // The reserved word reads zero and drops writes.
                    next_host_rdata = '0;
                end
            endcase
        end
        // Per-channel blocks share one layout, so only channel and
        // in-block offset are passed on.
        if (host_strobe && word_aligned && host_addr >= OFS_CHAN_BASE
                && host_addr < OFS_CHAN_END) begin
            next_chan_reg_hit = 1'b1;
            {next_chan_reg_index, next_chan_reg_offset} =
                chan_decode(host_addr);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fail_line_mask              <= RST_FAIL_MASK;
            irq_priority_level          <= RST_IRQ_LEVEL;
            fast_channel_trigger_select <= RST_SRC;
            outside_trigger_edge        <= RST_EDGE;
            soft_trigger_bits           <= RST_SOFT;
            arm_bits                    <= RST_ARM;
            outside_trigger_threshold   <= RST_THRESHOLD;
            host_rdata                  <= '0;
            host_ack                    <= 1'b0;
            chan_reg_hit                <= 1'b0;
            chan_reg_index              <= 3'h0;
            chan_reg_offset             <= 6'h00;
        end else begin
            fail_line_mask              <= next_fail_line_mask;
            irq_priority_level          <= next_irq_priority_level;
            fast_channel_trigger_select <= next_fast_channel_trigger_select;
            outside_trigger_edge        <= next_outside_trigger_edge;
            soft_trigger_bits           <= next_soft_trigger_bits;
            arm_bits                    <= next_arm_bits;
            outside_trigger_threshold   <= next_outside_trigger_threshold;
            host_rdata                  <= next_host_rdata;
            host_ack                    <= next_host_ack;
            chan_reg_hit                <= next_chan_reg_hit;
            chan_reg_index              <= next_chan_reg_index;
            chan_reg_offset             <= next_chan_reg_offset;
        end
    end

    agc_edge_detect #(
        .WIDTH (NUM_CHAN)
    ) u_soft_edges (
        .clock (clock),
        .rstn  (rstn),
        .level (soft_trigger_bits),
        .rise  (soft_rise),
        .fall  ()
    );

    agc_edge_detect #(
        .WIDTH (NUM_CHAN)
    ) u_arm_edges (
        .clock (clock),
        .rstn  (rstn),
        .level (arm_bits),
        .rise  (),
        .fall  (arm_fall)
    );

    agc_outside_trigger #(
        .WIDTH (LEVEL_W)
    ) u_outside (
        .clock        (clock),
        .rstn         (rstn),
        .threshold    (outside_trigger_threshold),
        .falling      (outside_trigger_edge),
        .sample_valid (outside_sample_valid),
        .sample       (outside_sample),
        .crossed      (outside_crossed)
    );

    // Triggers, aborts, fail line and interrupt level.
    always_comb begin
        // A held bit gives no second rise, so software must clear it
        // before another forced trigger is possible.
        next_channel_force_trigger = soft_rise & arm_bits;
        next_channel_abort         = arm_fall;
        case (fast_channel_trigger_select)
            3'h0, 3'h1, 3'h2, 3'h3: begin
                next_fast_channel_trigger =
                    slow_chan_trigger[fast_channel_trigger_select[1:0]];
            end
            SRC_EXTERNAL: begin
                next_fast_channel_trigger = outside_crossed;
            end
            default: begin
                // Invalid codes select nothing rather than a guess.
                next_fast_channel_trigger = 1'b0;
            end
        endcase
        next_sysfail_oe_n = !(card_fail && !fail_line_mask);
        if (irq_priority_level != IRQ_NONE && |chan_irq) begin
            next_irq_request_level = irq_priority_level;
        end else begin
            next_irq_request_level = IRQ_NONE;
        end
    end

    // The fast trigger output feeds channels 4 and 5 only; slow channels
    // take their own triggers and never see this source.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            channel_force_trigger <= '0;
            channel_abort         <= '0;
            fast_channel_trigger  <= 1'b0;
            sysfail_oe_n          <= 1'b1;
            irq_request_level     <= IRQ_NONE;
            channel_arm_bits      <= RST_ARM;
            sysfail_out           <= 1'b0;
        end else begin
            channel_force_trigger <= next_channel_force_trigger;
            channel_abort         <= next_channel_abort;
            fast_channel_trigger  <= next_fast_channel_trigger;
            sysfail_oe_n          <= next_sysfail_oe_n;
            irq_request_level     <= next_irq_request_level;
            channel_arm_bits      <= arm_bits;
            sysfail_out           <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// [tb/agc_global_regs_sva.sv]
/*
 * Checker bound to the global control registers.
 * Assumes one clock and an asynchronous active-low reset.
 */
`default_nettype none

module agc_global_regs_sva
    import agc_pkg::*;
(
    // Clock and reset
    input wire logic                clock,
    input wire logic                rstn,
    // Host port
    input wire logic                host_strobe,
    input wire logic                host_write,
    input wire logic [ADDR_W-1:0]   host_addr,
    input wire logic [DATA_W-1:0]   host_wdata,
    input wire logic [DATA_W-1:0]   host_rdata,
    input wire logic                host_ack,
    input wire logic                chan_reg_hit,
    // Fail line and interrupt
    input wire logic                card_fail,
    input wire logic                sysfail_oe_n,
    input wire logic [NUM_CHAN-1:0] chan_irq,
    input wire logic [2:0]          irq_request_level,
    // Triggers and channel control
    input wire logic [3:0]          slow_chan_trigger,
    input wire logic                fast_channel_trigger,
    input wire logic [NUM_CHAN-1:0] channel_force_trigger,
    input wire logic [NUM_CHAN-1:0] channel_abort
);
    timeunit 1ns;
    timeprecision 1ps;

    // Shadows of words 0x00 and 0x02, so pulses can be predicted here.
    logic [15:0] sh0;
    logic [15:0] sh2;
    logic [15:0] next_sh0;
    logic [15:0] next_sh2;
    logic [5:0]  exp_force;
    logic [5:0]  exp_abort;
    logic        slow_sel;

    always_comb begin
        next_sh0 = sh0;
        next_sh2 = sh2;
        exp_force = 6'h00;
        exp_abort = 6'h00;
        if (host_strobe && host_write && host_addr == OFS_FAIL_IRQ) begin
            next_sh0 = host_wdata;
        end
        if (host_strobe && host_write && host_addr == OFS_TRIG_ARM) begin
            next_sh2 = host_wdata;
            exp_force = host_wdata[11:6] & ~sh2[11:6] & host_wdata[5:0];
            exp_abort = sh2[5:0] & ~host_wdata[5:0];
        end
        slow_sel = slow_chan_trigger[sh2[14:13]];
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sh0 <= 16'h0000;
            sh2 <= 16'h0000;
        end else begin
            sh0 <= next_sh0;
            sh2 <= next_sh2;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence s_take;
        host_strobe && !host_addr[0];
    endsequence
    sequence s_read;
        s_take ##0 !host_write;
    endsequence

    AST_ACK: assert property (s_take ##0 host_addr < OFS_CHAN_BASE |=> host_ack)
        else $error("global access not acknowledged");
    AST_ODD: assert property (host_strobe && host_addr[0] |=> !host_ack && !chan_reg_hit)
        else $error("odd address answered");
    AST_HIT: assert property (s_take ##0 host_addr >= OFS_CHAN_BASE && host_addr < OFS_CHAN_END |=> chan_reg_hit && !host_ack)
        else $error("channel block access not decoded");
    AST_RSVD: assert property (s_read ##0 host_addr == OFS_RESERVED |=> host_rdata == 16'h0000)
        else $error("reserved word not zero");
    AST_FAIL_ON: assert property (card_fail && !sh0[14] |=> !sysfail_oe_n)
        else $error("fail line not driven");
    AST_FAIL_OFF: assert property (!card_fail || sh0[14] |=> sysfail_oe_n)
        else $error("fail line driven while masked or idle");
    AST_IRQ: assert property ((|chan_irq) |=> irq_request_level == $past(sh0[2:0]))
        else $error("wrong request level");
    AST_FORCE: assert property (1'b1 |-> ##2 channel_force_trigger == $past(exp_force, 2))
        else $error("force pulse wrong");
    AST_ABORT: assert property (1'b1 |-> ##2 channel_abort == $past(exp_abort, 2))
        else $error("abort pulse wrong");
    AST_SRC_SLOW: assert property (!sh2[15] |=> fast_channel_trigger == $past(slow_sel))
        else $error("slow channel source not followed");
endmodule

`default_nettype wire

// [tb/agc_host_model.sv]
/*
 * Host side of the register port, one access at a time.
 * Assumes its task is called from a single process of the bench.
 */
`default_nettype none

module agc_host_model
    import agc_pkg::*;
(
    // Clock
    input  wire logic              clock,
    // Request
    output logic                   host_strobe,
    output logic                   host_write,
    output logic      [ADDR_W-1:0] host_addr,
    output logic      [DATA_W-1:0] host_wdata,
    // Answer
    input  wire logic [DATA_W-1:0] host_rdata,
    input  wire logic              host_ack,
    input  wire logic              chan_reg_hit
);
    timeunit 1ns;
    timeprecision 1ps;

    initial {host_strobe, host_write, host_addr, host_wdata} = '0;

    // Only single 16-bit accesses are issued; ok 1 is ack, 2 is decode.
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [15:0] d, output logic [15:0] rd,
                          output logic [1:0] ok);
        ok = 2'h0;
        rd = 16'h0000;
        @(posedge clock);
        #1;
        host_strobe = 1'b1;
        host_write = wr;
        host_addr = a;
        host_wdata = d;
        @(posedge clock);
        #1;
        host_strobe = 1'b0;
        for (int i = 0; i < 4 && ok == 2'h0; i++) begin
            if (host_ack === 1'b1) begin
                ok = 2'h1;
                rd = host_rdata;
            end else if (chan_reg_hit === 1'b1) begin
                ok = 2'h2;
            end else begin
                @(posedge clock);
                #1;
            end
        end
        // Released lines show the inverse so a stale value is never trusted.
        host_addr = ~a;
        host_wdata = ~d;
    endtask
endmodule

`default_nettype wire

// [tb/acquisition_global_control_regs_tb_top.sv]
/*
 * Self-checking bench for the global control registers.
 * Assumes the package, design, host model and checker are compiled first.
 */
`default_nettype none

`define CHK(a, b) \
    begin \
        compares++; \
        if ((a) !== (b)) begin \
            err_count++; \
            $display("CHECK FAILED at %0t: got %h want %h", $time, a, b); \
        end \
    end

module acquisition_global_control_regs_tb_top
    import agc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] SEQ [6] = '{16'h0000, 16'h0FFF, 16'h0FFF,
                                         16'h003F, 16'h0FC0, 16'h0000};
    localparam logic [7:0]  ADRS [5] = '{8'h03, 8'h30, 8'h5A, 8'hF6, 8'hF8};
    localparam logic [1:0]  WANT [5] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h0};

    logic        clock, rstn, host_strobe, host_write, host_ack;
    logic [7:0]  host_addr;
    logic [15:0] host_wdata, host_rdata, m0, m2, m6, d, rd;
    logic        chan_reg_hit, card_fail, sysfail_out, sysfail_oe_n;
    logic [2:0]  chan_reg_index, irq_request_level;
    logic [5:0]  chan_reg_offset, chan_irq, channel_arm_bits;
    logic [5:0]  channel_force_trigger, channel_abort;
    logic [3:0]  slow_chan_trigger;
    logic        outside_sample_valid, fast_channel_trigger, have_prev;
    logic [11:0] outside_sample, prev;
    logic [31:0] seed;
    int          err_count;
    int          compares;

    agc_global_regs agc_global_regs_inst (.*);

    agc_host_model agc_host_model_inst (.*);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic print_verdict();
        $display("mismatches %0d, compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic acc(input logic wr, input logic [7:0] a,
                       input logic [15:0] dw, input logic [1:0] want);
        logic [1:0] ok;
        agc_host_model_inst.access(wr, a, dw, rd, ok);
        `CHK(ok, want);
        if (ok !== want && want != 2'h0) begin
            print_verdict();
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [15:0] dw);
        acc(1'b1, a, dw, 2'h1);
        case (a)
            OFS_FAIL_IRQ: m0 = dw & 16'h4007;
            OFS_TRIG_ARM: m2 = dw;
            OFS_THRESHOLD: m6 = dw & 16'h0FFF;
            default: ;
        endcase
    endtask

    task automatic rreg(input logic [7:0] a);
        logic [15:0] want;
        want = (a == OFS_FAIL_IRQ) ? m0 : (a == OFS_TRIG_ARM) ? m2 :
               (a == OFS_THRESHOLD) ? m6 : 16'h0000;
        acc(1'b0, a, 16'h0000, 2'h1);
        `CHK(rd, want);
    endtask

    task automatic w02(input logic [15:0] dw);
        logic [15:0] old;
        old = m2;
        wreg(OFS_TRIG_ARM, dw);
        @(posedge clock);
        #1;
        `CHK(channel_force_trigger, dw[11:6] & ~old[11:6] & dw[5:0]);
        `CHK(channel_abort, old[5:0] & ~dw[5:0]);
        `CHK(channel_arm_bits, dw[5:0]);
    endtask

    task automatic samp(input logic [11:0] v);
        logic want;
        want = have_prev && (m2[12] ? (prev >= m6[11:0] && v < m6[11:0])
                                    : (prev < m6[11:0] && v >= m6[11:0]));
        outside_sample_valid = 1'b1;
        outside_sample = v;
        @(posedge clock);
        #1;
        outside_sample_valid = 1'b0;
        outside_sample = ~v;
        prev = v;
        have_prev = 1'b1;
        `CHK(fast_channel_trigger, want);
    endtask

    initial begin
        clock = 1'b0;
        forever begin
            #4 clock = ~clock;
        end
    end

    initial begin
        rstn = 1'b0;
        card_fail = 1'b0;
        chan_irq = 6'h00;
        slow_chan_trigger = 4'h0;
        outside_sample_valid = 1'b0;
        outside_sample = 12'h000;
        {m0, m2, m6, prev, have_prev} = '0;
        seed = 32'hD95D;
        err_count = 0;
        compares = 0;
        repeat (6) @(posedge clock);
        #1;
        rstn = 1'b1;
        `CHK(sysfail_oe_n, 1'b1);
        for (int a = 0; a < 8; a += 2) begin
            rreg(8'(a));
        end
        repeat (12) begin
            d = 16'(rnd());
            wreg(OFS_FAIL_IRQ, d);
            wreg(OFS_RESERVED, d);
            wreg(OFS_THRESHOLD, d);
            w02(d);
            for (int a = 0; a < 8; a += 2) begin
                rreg(8'(a));
            end
        end
        // Held soft bits fire once; a soft rise with arm cleared gives no force, and clearing arm aborts.
        foreach (SEQ[i]) begin
            w02(SEQ[i]);
        end
        foreach (ADRS[i]) begin
            acc(1'b0, ADRS[i], 16'h0000, WANT[i]);
            if (WANT[i] == 2'h2) begin
                `CHK(chan_reg_index, 3'((ADRS[i] - 8) / 40));
                `CHK(chan_reg_offset, 6'((ADRS[i] - 8) % 40));
            end
        end
        for (int m = 0; m < 2; m++) begin
            wreg(OFS_FAIL_IRQ, 16'(m) << 14);
            card_fail = 1'b1;
            @(posedge clock);
            #1;
            `CHK(sysfail_oe_n, m[0]);
            `CHK(sysfail_out, 1'b0);
            card_fail = 1'b0;
        end
        for (int l = 0; l < 8; l++) begin
            wreg(OFS_FAIL_IRQ, 16'(l));
            chan_irq = 6'(rnd()) | 6'h01;
            @(posedge clock);
            #1;
            `CHK(irq_request_level, 3'(l));
            chan_irq = 6'h00;
        end
        for (int s = 0; s < 8; s++) begin
            w02({3'(s), 13'h0000});
            for (int k = 0; k < 4; k++) begin
                slow_chan_trigger = 4'h1 << k;
                @(posedge clock);
                #1;
                slow_chan_trigger = 4'h0;
                `CHK(fast_channel_trigger, s == k);
            end
        end
        wreg(OFS_THRESHOLD, 16'hF800);
        w02(16'hC000);
        samp(12'h100);
        samp(12'h900);
        samp(12'h900);
        samp(12'h100);
        w02(16'hD000);
        samp(12'h900);
        samp(12'h100);
        print_verdict();
    end
endmodule

bind agc_global_regs agc_global_regs_sva agc_global_regs_sva_inst (.*);

`default_nettype wire
